// *** rtl/msmd_top.sv ***
// Operating-mode capture, priority/mode register and on-chip memory map decoder
`timescale 1ns/1ps
//
// Contract
// [RULE1] Decoder ranks register block over RAM over ROM on overlaps.
// [RULE2] Bootloader ROM mapped only after reset in bootstrap mode.
// [RULE3] Expanded modes: program ROM enabled only when ROM-enable bit set.
// [RULE4] Single-chip and bootstrap: program ROM always enabled.
// [RULE5] 512-byte EEPROM fixed at B600-B7FF, not relocatable.
// [RULE6] 2048-byte EEPROM defaults to F800, movable by four-bit field.
// [RULE7] Mode taken from pins only during reset, later changes ignored.
// [RULE8] Pin pair decodes to boot select, special and mode-A flags.
// [RULE9] Mode-A pin is open-drain low strobe on first instruction cycle.
// [RULE10] Normal modes fetch reset vector from FFFA-FFFF.
// [RULE11] Special modes fetch vector from BFFA-BFFF, test features allowed.
// [RULE12] Priority/mode register at 103C with fixed bit layout.
// [RULE13] Boot select effective only when special; writable only in special.
// [RULE14] Boot select 1 maps boot ROM BE00-BFFF, 0 removes it.
// [RULE15] Special flag loads inverse of pin B, mode-A flag loads pin A.
// [RULE16] Both flags always readable, freely writable in special modes.
// [RULE17] Normal modes: only first mode-A flag write after reset taken.
// [RULE18] Cleared special flag cannot be set again until reset.
// [RULE19] Read-visibility bit written once; resets 1 in test, else 0.
// [RULE20] Register block at 1000, RAM at 0000, both page-relocatable.
// [RULE21] Mode flags captured in clocked flops at reset release.
module msmd_top #(
   parameter int RAM_BYTES = 512,
   parameter logic [15:0] ROM_BASE = 16'hD000,
   parameter logic [1:0] EE_KIND = 2'h1
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic mode_pin_a,
   input wire logic mode_pin_b,
   output logic mode_pin_a_out,
   output logic mode_pin_a_oe_n,
   input wire logic cpu_first_cycle,
   input wire logic [15:0] cpu_addr,
   output msmd_pkg::msmd_sel_s cpu_sel,
   output msmd_pkg::msmd_mode_s mode_flags,
   output logic [15:0] reset_vector_base,
   output logic test_features_en,
   output logic mode_captured
);
   import msmd_pkg::*;
   `include "msmd_regs.svh"

   // ----------------------------------------------------------------------
   // Mode pin synchronisers
   // ----------------------------------------------------------------------
   // No reset here: the straps are stable while reset is held, so the
   // chain is already settled at the first edge after release.
   logic [1:0] pa_sync;
   logic [1:0] pb_sync;
   logic pa_s3;
   logic pb_s3;

   always_ff @(posedge hclk) begin
      pa_sync <= {pa_sync[0], mode_pin_a};
      pb_sync <= {pb_sync[0], mode_pin_b};
      pa_s3 <= pa_sync[1];
      pb_s3 <= pb_sync[1];
   end

   wire logic pins_agree = (pa_sync[1] == pa_s3) && (pb_sync[1] == pb_s3);

   // ----------------------------------------------------------------------
   // Capture sequencing
   // ----------------------------------------------------------------------
   msmd_state_e state;
   wire logic capture = (state == MSMD_ST_CAPTURE) && pins_agree;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state <= MSMD_ST_CAPTURE;
      end else begin
         case (state)
            MSMD_ST_CAPTURE: begin
               if (pins_agree) begin
                  state <= MSMD_ST_RUN; // RULE7
               end
            end
            MSMD_ST_RUN: begin
               state <= MSMD_ST_RUN;
            end
            default: begin
               state <= MSMD_ST_CAPTURE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // AHB-Lite slave: one wait state, write applied in the data phase
   // ----------------------------------------------------------------------
   logic dp_active;
   logic dp_write;
   logic [31:0] dp_addr;

   wire logic take = hsel && htrans[1] && hready;
   wire logic wr_now = dp_active && dp_write && !hreadyout;
   wire logic wr_prio = wr_now && (dp_addr == `MSMD_OFS_PRIO); // RULE12
   wire logic wr_cfg = wr_now && (dp_addr == `MSMD_OFS_CFG);
   wire logic wr_map = wr_now && (dp_addr == `MSMD_OFS_MAP);
   wire logic [7:0] wbyte = hwdata[7:0];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_active <= 1'b0;
         dp_write <= 1'b0;
         dp_addr <= 32'h0000_0000;
         hreadyout <= 1'b1;
      end else if (take) begin
         dp_active <= 1'b1;
         dp_write <= hwrite;
         dp_addr <= haddr;
         hreadyout <= 1'b0;
      end else if (dp_active && !hreadyout) begin
         hreadyout <= 1'b1;
      end else begin
         dp_active <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // Priority and mode register
   // ----------------------------------------------------------------------
   logic boot_sel;
   logic special;
   logic mode_a;
   logic rd_vis;
   logic [3:0] psel;
   logic mode_a_written;
   logic rd_vis_written;
   logic special_at_reset;
   logic mode_a_at_reset;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         boot_sel <= 1'b0;
         special <= 1'b0;
         mode_a <= 1'b0;
         rd_vis <= 1'b0;
         special_at_reset <= 1'b0;
         mode_a_at_reset <= 1'b0;
      end else if (capture) begin
         boot_sel <= !pb_s3 && !pa_s3; // RULE8 RULE21
         special <= !pb_s3; // RULE15
         mode_a <= pa_s3; // RULE15
         rd_vis <= !pb_s3 && pa_s3; // RULE19
         special_at_reset <= !pb_s3;
         mode_a_at_reset <= pa_s3;
      end else if (wr_prio) begin
         if (special) begin
            boot_sel <= wbyte[`MSMD_BIT_BOOT]; // RULE13
            mode_a <= wbyte[`MSMD_BIT_MODEA]; // RULE16
         end else if (!mode_a_written) begin
            mode_a <= wbyte[`MSMD_BIT_MODEA]; // RULE17
         end
         // Clearing is allowed, setting back is not
         special <= special && wbyte[`MSMD_BIT_SPECIAL]; // RULE16 RULE18
         if (!rd_vis_written) begin
            rd_vis <= wbyte[`MSMD_BIT_RDVIS]; // RULE19
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mode_a_written <= 1'b0;
         rd_vis_written <= 1'b0;
         psel <= `MSMD_PSEL_RESET;
      end else if (wr_prio && state == MSMD_ST_RUN) begin
         // Any write counts, so leaving special mode does not reopen the once-only write
         mode_a_written <= 1'b1; // RULE17
         rd_vis_written <= 1'b1; // RULE19
         psel <= wbyte[`MSMD_PSEL_HI:`MSMD_PSEL_LO];
      end
   end

   // ----------------------------------------------------------------------
   // Configuration latches and RAM/register page map
   // ----------------------------------------------------------------------
   logic rom_enable_cfg;
   logic [3:0] eeprom_map_field;
   logic [3:0] ram_page;
   logic [3:0] reg_page;
   logic map_written;
   localparam logic [7:0] CFG_RST = `MSMD_CFG_RESET;
   localparam logic [7:0] MAP_RST = `MSMD_MAP_RESET;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rom_enable_cfg <= CFG_RST[`MSMD_BIT_ROMEN];
         eeprom_map_field <= CFG_RST[`MSMD_EEMAP_HI:`MSMD_EEMAP_LO];
      end else if (wr_cfg) begin
         rom_enable_cfg <= wbyte[`MSMD_BIT_ROMEN];
         eeprom_map_field <= wbyte[`MSMD_EEMAP_HI:`MSMD_EEMAP_LO]; // RULE6
      end
   end

   // Normal modes may set the map once; special modes any number of times
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ram_page <= MAP_RST[`MSMD_RAMPG_HI:`MSMD_RAMPG_LO]; // RULE20
         reg_page <= MAP_RST[`MSMD_REGPG_HI:`MSMD_REGPG_LO]; // RULE20
         map_written <= 1'b0;
      end else if (wr_map && (special || !map_written)) begin
         ram_page <= wbyte[`MSMD_RAMPG_HI:`MSMD_RAMPG_LO]; // RULE20
         reg_page <= wbyte[`MSMD_REGPG_HI:`MSMD_REGPG_LO]; // RULE20
         map_written <= 1'b1;
      end
   end

   // ----------------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------------
   logic [7:0] next_rbyte;
   wire logic rom_on = !mode_a_at_reset || rom_enable_cfg; // RULE3 RULE4
   wire logic boot_on = special && boot_sel; // RULE13 RULE2

   always_comb begin
      next_rbyte = 8'h00;
      case (dp_addr)
         `MSMD_OFS_PRIO: next_rbyte = {boot_sel, special, mode_a, rd_vis, psel}; // RULE16
         `MSMD_OFS_CFG: next_rbyte = {eeprom_map_field, 3'h0, rom_enable_cfg};
         `MSMD_OFS_MAP: next_rbyte = {ram_page, reg_page};
         `MSMD_OFS_STAT: next_rbyte = {4'h0, boot_on, rom_on, special_at_reset, mode_a_at_reset};
         default: next_rbyte = 8'h00;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
         hresp <= 1'b0;
      end else if (dp_active && !dp_write && !hreadyout) begin
         hrdata <= {24'h00_0000, next_rbyte};
         hresp <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // Address decoder
   // ----------------------------------------------------------------------
   msmd_sel_s next_sel;
   logic [16:0] reg_lo;
   logic [16:0] ram_lo;
   logic [15:0] ee2k_lo;
   logic in_reg;
   logic in_ram;
   logic in_boot;
   logic in_rom;
   logic in_ee;

   always_comb begin
      reg_lo = {1'b0, reg_page, `MSMD_PAGE_OFS0};
      ram_lo = {1'b0, ram_page, `MSMD_PAGE_OFS0};
      ee2k_lo = {eeprom_map_field, `MSMD_EE2K_OFS};
      in_reg = ({1'b0, cpu_addr} >= reg_lo) && ({1'b0, cpu_addr} < reg_lo + `MSMD_REGBLK_BYTES);
      in_ram = ({1'b0, cpu_addr} >= ram_lo) && ({1'b0, cpu_addr} < ram_lo + 17'(RAM_BYTES));
      in_boot = boot_on && cpu_addr >= `MSMD_BOOT_LO && cpu_addr <= `MSMD_BOOT_HI; // RULE14
      in_rom = rom_on && cpu_addr >= ROM_BASE; // RULE3 RULE4
      if (EE_KIND == `MSMD_EE_512) begin
         in_ee = cpu_addr >= `MSMD_EE512_LO && cpu_addr <= `MSMD_EE512_HI; // RULE5
      end else if (EE_KIND == `MSMD_EE_2K) begin
         in_ee = cpu_addr[15:11] == ee2k_lo[15:11]; // RULE6
      end else begin
         in_ee = 1'b0;
      end
      next_sel = '0;
      if (in_reg) begin
         next_sel.reg_blk = 1'b1; // RULE1
      end else if (in_ram) begin
         next_sel.ram = 1'b1; // RULE1
      end else if (in_boot) begin
         next_sel.boot = 1'b1;
      end else if (in_rom) begin
         next_sel.rom = 1'b1; // RULE1
      end else if (in_ee) begin
         next_sel.eeprom = 1'b1;
      end else begin
         next_sel.ext = 1'b1;
      end
   end

   // Registered select costs one cycle of latency but keeps outputs glitch-free
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cpu_sel <= '0;
      end else begin
         cpu_sel <= next_sel;
      end
   end

   // ----------------------------------------------------------------------
   // Mode outputs, vector base and instruction strobe
   // ----------------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mode_flags <= '0;
         reset_vector_base <= `MSMD_VEC_NORMAL;
         test_features_en <= 1'b0;
         mode_captured <= 1'b0;
      end else begin
         mode_flags <= '{boot_rom_select: boot_sel, special_mode_flag: special, mode_a_flag: mode_a};
         reset_vector_base <= special_at_reset ? `MSMD_VEC_SPECIAL : `MSMD_VEC_NORMAL; // RULE10 RULE11
         test_features_en <= special; // RULE11
         mode_captured <= state == MSMD_ST_RUN;
      end
   end

   // Pin is released during reset and capture so the strap can be read
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mode_pin_a_out <= 1'b0;
         mode_pin_a_oe_n <= 1'b1;
      end else begin
         mode_pin_a_out <= 1'b0;
         mode_pin_a_oe_n <= !(state == MSMD_ST_RUN && cpu_first_cycle); // RULE9
      end
   end

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   a_special_stays_clear: assert property (@(posedge hclk) disable iff (!hresetn) // RULE18
      (state == MSMD_ST_RUN && !special) |=> !special)
      else $error("special flag set again after clear");

   a_capture_decode: assert property (@(posedge hclk) disable iff (!hresetn) // RULE8
      // Release edge still sees reset in the flops, so it is no capture edge
      (capture && hresetn) |=> (special == !$past(pb_s3)) && (mode_a == $past(pa_s3))
                  && (boot_sel == (!$past(pb_s3) && !$past(pa_s3))))
      else $error("mode flags wrong after capture");

   a_mode_pins_ignored: assert property (@(posedge hclk) disable iff (!hresetn) // RULE7
      (state == MSMD_ST_RUN && !wr_prio) |=> $stable(special) && $stable(mode_a))
      else $error("mode flags moved without a write");

   a_normal_mode_a_once: assert property (@(posedge hclk) disable iff (!hresetn) // RULE17
      (wr_prio && !special && mode_a_written) |=> $stable(mode_a))
      else $error("second mode-A write taken in normal mode");

   a_boot_write_guard: assert property (@(posedge hclk) disable iff (!hresetn) // RULE13
      (!special && !capture) |=> $stable(boot_sel))
      else $error("boot select changed outside special mode");

   a_reg_over_ram: assert property (@(posedge hclk) disable iff (!hresetn) // RULE1
      in_reg |=> cpu_sel.reg_blk && !cpu_sel.ram && !cpu_sel.rom)
      else $error("register block lost priority");

   a_ram_over_rom: assert property (@(posedge hclk) disable iff (!hresetn) // RULE1
      (in_ram && !in_reg) |=> cpu_sel.ram && !cpu_sel.rom)
      else $error("RAM lost priority over ROM");

   a_boot_absent: assert property (@(posedge hclk) disable iff (!hresetn) // RULE14
      !boot_on |=> !cpu_sel.boot)
      else $error("boot ROM selected while disabled");

   a_rom_single_chip: assert property (@(posedge hclk) disable iff (!hresetn) // RULE4
      (state == MSMD_ST_RUN && !mode_a_at_reset && cpu_addr >= ROM_BASE && !in_reg && !in_ram && !in_boot)
      |=> cpu_sel.rom)
      else $error("program ROM missing in single-chip mode");

   a_vector_base: assert property (@(posedge hclk) disable iff (!hresetn) // RULE10
      $rose(mode_captured) |-> reset_vector_base == (special_at_reset ? `MSMD_VEC_SPECIAL : `MSMD_VEC_NORMAL))
      else $error("reset vector base wrong");

   a_strobe_pulse: assert property (@(posedge hclk) disable iff (!hresetn) // RULE9
      (state == MSMD_ST_RUN && cpu_first_cycle) |=> !mode_pin_a_oe_n ##1 (mode_pin_a_oe_n || $past(cpu_first_cycle)))
      else $error("instruction strobe not driven");

   a_bus_one_wait: assert property (@(posedge hclk) disable iff (!hresetn)
      take |=> !hreadyout ##1 hreadyout)
      else $error("bus answer not after one wait state");

endmodule // msmd_top

// *** common/msmd_regs.svh ***
// Register offsets, field positions, reset values and map addresses of the mode/map block
`ifndef MSMD_REGS_SVH
`define MSMD_REGS_SVH

// ----------------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------------
`define MSMD_OFS_PRIO        32'h0000_103C
`define MSMD_OFS_CFG         32'h0000_1040
`define MSMD_OFS_MAP         32'h0000_1044
`define MSMD_OFS_STAT        32'h0000_1048

// ----------------------------------------------------------------------------
// Priority and mode register fields
// ----------------------------------------------------------------------------
`define MSMD_BIT_BOOT        7
`define MSMD_BIT_SPECIAL     6
`define MSMD_BIT_MODEA       5
`define MSMD_BIT_RDVIS       4
`define MSMD_PSEL_HI         3
`define MSMD_PSEL_LO         0
`define MSMD_PSEL_RESET      4'h6

// ----------------------------------------------------------------------------
// Configuration latch and map register fields, reset values
// ----------------------------------------------------------------------------
`define MSMD_BIT_ROMEN       0
`define MSMD_EEMAP_HI        7
`define MSMD_EEMAP_LO        4
`define MSMD_CFG_RESET       8'hF1
`define MSMD_RAMPG_HI        7
`define MSMD_RAMPG_LO        4
`define MSMD_REGPG_HI        3
`define MSMD_REGPG_LO        0
`define MSMD_MAP_RESET       8'h01

// ----------------------------------------------------------------------------
// Fixed map addresses
// ----------------------------------------------------------------------------
`define MSMD_REGBLK_BYTES    17'h0_0040
`define MSMD_BOOT_LO         16'hBE00
`define MSMD_BOOT_HI         16'hBFFF
`define MSMD_EE512_LO        16'hB600
`define MSMD_EE512_HI        16'hB7FF
`define MSMD_EE2K_OFS        12'h800
`define MSMD_PAGE_OFS0       12'h000
`define MSMD_VEC_NORMAL      16'hFFFA
`define MSMD_VEC_SPECIAL     16'hBFFA
`define MSMD_EE_NONE         2'h0
`define MSMD_EE_512          2'h1
`define MSMD_EE_2K           2'h2

`endif

// *** common/msmd_pkg.sv ***
// Types shared by the mode/map block
package msmd_pkg;

   typedef enum logic [1:0] {
      MSMD_ST_CAPTURE = 2'b01,
      MSMD_ST_RUN     = 2'b10
   } msmd_state_e;

   typedef struct packed {
      logic reg_blk;
      logic ram;
      logic boot;
      logic rom;
      logic eeprom;
      logic ext;
   } msmd_sel_s;

   typedef struct packed {
      logic boot_rom_select;
      logic special_mode_flag;
      logic mode_a_flag;
   } msmd_mode_s;

endpackage

// *** verification/msmd_strap_model.sv ***
// Board strap resistors of the two mode pins and open-drain wiring of mode pin A
`timescale 1ns/1ps
module msmd_strap_model (
   input wire logic strap_a,
   input wire logic strap_b,
   input wire logic pin_a_out,
   input wire logic pin_a_oe_n,
   output logic mode_pin_a,
   output logic mode_pin_b
);
   // Pull-up keeps the strap level unless the device sinks the line
   assign mode_pin_a = (!pin_a_oe_n && !pin_a_out) ? 1'b0 : strap_a;
   assign mode_pin_b = strap_b;
endmodule // msmd_strap_model

// *** verification/tb_top.sv ***
// Self-checking bench for mode capture, mode register and memory map decode
`timescale 1ns/1ps
`include "msmd_regs.svh"
module tb_top;
   import msmd_pkg::*;
   logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, rdy_smp;
   logic [31:0] haddr, hwdata, hrdata, rd, rd_smp, r;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic strap_a, strap_b, mode_pin_a, mode_pin_b, pin_a_out, pin_a_oe_n;
   logic cpu_first_cycle, test_features_en, mode_captured, a_rst;
   logic [15:0] cpu_addr, reset_vector_base;
   msmd_sel_s cpu_sel, cpu_sel2;
   msmd_mode_s mode_flags;
   logic [7:0] prio, cfg;
   logic [3:0] regpg, rampg;
   int fails, check_count, seed, nwr;
   int cyc = 0;

   assign hready = hreadyout;
   msmd_top #(.RAM_BYTES(512), .ROM_BASE(16'hD000), .EE_KIND(2'h1)) u_dut (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .mode_pin_a(mode_pin_a),
      .mode_pin_b(mode_pin_b), .mode_pin_a_out(pin_a_out), .mode_pin_a_oe_n(pin_a_oe_n),
      .cpu_first_cycle(cpu_first_cycle), .cpu_addr(cpu_addr), .cpu_sel(cpu_sel), .mode_flags(mode_flags),
      .reset_vector_base(reset_vector_base), .test_features_en(test_features_en),
      .mode_captured(mode_captured));
   msmd_strap_model u_strap (.strap_a(strap_a), .strap_b(strap_b), .pin_a_out(pin_a_out),
      .pin_a_oe_n(pin_a_oe_n), .mode_pin_a(mode_pin_a), .mode_pin_b(mode_pin_b));
   // Second copy with the relocatable 2K EEPROM and ROM shrunk to the top byte
   msmd_top #(.RAM_BYTES(512), .ROM_BASE(16'hFFFF), .EE_KIND(2'h2)) u_dut_ee2k (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hreadyout(), .hresp(), .hrdata(), .mode_pin_a(mode_pin_a), .mode_pin_b(mode_pin_b),
      .mode_pin_a_out(), .mode_pin_a_oe_n(), .cpu_first_cycle(cpu_first_cycle), .cpu_addr(cpu_addr),
      .cpu_sel(cpu_sel2), .mode_flags(), .reset_vector_base(), .test_features_en(), .mode_captured());

   // ----------------------------------------------------------------------------
   // Clock, edge sampling and hang guard
   // ----------------------------------------------------------------------------
   initial begin
      hclk = 1'b0;
      forever #2 hclk = ~hclk;
   end
   // Registered outputs only move on rising edges, so the falling edge shows what the next rise samples
   always @(negedge hclk) begin
      rdy_smp = hreadyout;
      rd_smp = hrdata;
   end
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 8000) begin
         fails++;
         give_verdict();
      end
   end

   // ----------------------------------------------------------------------------
   // Tasks and expectations
   // ----------------------------------------------------------------------------
   task automatic give_verdict();
      if (fails == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic chk_sel(input logic [15:0] a, input msmd_sel_s exp);
      check_count++;
      if (cpu_sel !== exp) begin
         fails++;
         $display("ERROR cpu_sel at %h expected %b seen %b", a, exp, cpu_sel);
      end
   endtask
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= w;
      hsize <= 3'b010;
      do @(posedge hclk); while (rdy_smp !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge hclk); while (rdy_smp !== 1'b1);
      rd = rd_smp;
   endtask
   function automatic msmd_sel_s exp_sel(input logic [15:0] a);
      msmd_sel_s s;
      s = '0;
      if (a[15:12] == regpg && a[11:0] < 12'h040) s.reg_blk = 1'b1;
      else if (a[15:12] == rampg && a[11:0] < 12'h200) s.ram = 1'b1;
      else if (prio[6] && prio[7] && a >= `MSMD_BOOT_LO && a <= `MSMD_BOOT_HI) s.boot = 1'b1;
      else if ((!a_rst || cfg[0]) && a >= 16'hD000) s.rom = 1'b1;
      else if (a >= `MSMD_EE512_LO && a <= `MSMD_EE512_HI) s.eeprom = 1'b1;
      else s.ext = 1'b1;
      return s;
   endfunction
   function automatic logic exp_ee2k(input logic [15:0] a);
      msmd_sel_s s;
      s = exp_sel(a);
      if (s.reg_blk || s.ram || s.boot || ((!a_rst || cfg[0]) && a == 16'hFFFF)) return 1'b0;
      return a[15:11] == {cfg[7:4], 1'b1};
   endfunction
   task automatic decode(input logic [15:0] a);
      @(posedge hclk);
      cpu_addr <= a;
      @(posedge hclk);
      @(negedge hclk);
      chk_sel(a, exp_sel(a));
      chk_val("ee2k_sel", exp_ee2k(a), cpu_sel2.eeprom);
   endtask
   task automatic sweep();
      logic [15:0] corner [14] = '{16'h0000, 16'h003F, 16'h0040, 16'h01FF, 16'h1000, 16'h103F, 16'h0800,
                                   16'hB600, 16'hB7FF, 16'hBE00, 16'hBFFF, 16'hD000, 16'hF800, 16'hFFFF};
      for (int i = 0; i < 14; i++) decode(corner[i]);
      for (int i = 0; i < 24; i++) decode(16'($random(seed)));
   endtask
   task automatic read_prio();
      bus(1'b0, `MSMD_OFS_PRIO, 32'h0);
      chk_val("priority_and_mode_register", {24'h0, prio}, rd);
      @(negedge hclk);
      chk_val("mode_flags", prio[7:5], mode_flags);
   endtask
   task automatic prio_write(input logic [7:0] wd);
      logic [7:0] n;
      n = {prio[7:4], wd[3:0]};
      if (prio[6]) n[7] = wd[7];
      if (prio[6] || nwr == 0) n[5] = wd[5];
      if (nwr == 0) n[4] = wd[4];
      n[6] = prio[6] & wd[6];
      nwr++;
      bus(1'b1, `MSMD_OFS_PRIO, {24'h0, wd});
      prio = n;
      read_prio();
   endtask

   // ----------------------------------------------------------------------------
   // Main sequence: every strap setting in turn
   // ----------------------------------------------------------------------------
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      htrans = 2'b00;
      haddr = 32'h0;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h0;
      cpu_first_cycle = 1'b0;
      cpu_addr = 16'h0;
      strap_a = 1'b0;
      strap_b = 1'b1;
      fails = 0;
      check_count = 0;
      seed = 41565;
      for (int m = 0; m < 4; m++) begin
         @(posedge hclk);
         hresetn <= 1'b0;
         strap_b <= m[1];
         strap_a <= m[0];
         repeat (12) @(posedge hclk);
         chk_val("mode_pin_a_oe_n", 32'h1, pin_a_oe_n);
         hresetn <= 1'b1;
         repeat (3) @(posedge hclk);
         a_rst = m[0];
         prio = {~m[1] & ~m[0], ~m[1], m[0], ~m[1] & m[0], `MSMD_PSEL_RESET};
         cfg = `MSMD_CFG_RESET;
         regpg = 4'h1;
         rampg = 4'h0;
         nwr = 0;
         @(negedge hclk);
         chk_val("mode_flags", prio[7:5], mode_flags);
         chk_val("reset_vector_base", m[1] ? `MSMD_VEC_NORMAL : `MSMD_VEC_SPECIAL, reset_vector_base);
         chk_val("test_features_en", !m[1], test_features_en);
         chk_val("mode_captured", 32'h1, mode_captured);
         // Straps flip after release and must leave the mode alone
         @(posedge hclk);
         strap_a <= ~m[0];
         strap_b <= ~m[1];
         repeat (6) @(posedge hclk);
         read_prio();
         sweep();
         @(posedge hclk);
         cpu_first_cycle <= 1'b1;
         @(posedge hclk);
         cpu_first_cycle <= 1'b0;
         @(negedge hclk);
         chk_val("mode_pin_a_oe_n", 32'h0, pin_a_oe_n);
         chk_val("mode_pin_a", 32'h0, mode_pin_a);
         @(negedge hclk);
         chk_val("mode_pin_a_oe_n", 32'h1, pin_a_oe_n);
         bus(1'b0, 32'h0000_2000, 32'h0);
         chk_val("unmapped", 32'h0, rd);
         chk_val("hresp", 32'h0, hresp);
         cfg = 8'h00;
         bus(1'b1, `MSMD_OFS_CFG, {24'h0, cfg});
         r = $random(seed);
         rampg = r[3:0];
         regpg = r[3:0];
         bus(1'b1, `MSMD_OFS_MAP, {24'h0, rampg, regpg});
         prio_write({~prio[7], 1'b1, ~prio[5], ~prio[4], r[7:4]});
         sweep();
         prio_write({prio[7], 1'b0, ~prio[5], ~prio[4], r[11:8]});
         prio_write({prio[7], 1'b1, ~prio[5], prio[4], r[15:12]});
         sweep();
      end
      give_verdict();
   end
endmodule // tb_top
